// [core/anpm_monitor.sv]
`timescale 1ns/100ps

module anpm_monitor (
  // Clock and reset
  input  wire logic                                 i_mclk,
  input  wire logic                                 i_nrst,
  // Register port
  input  wire anpm_pkg::anpm_req_t                  i_req,
  output logic      [anpm_pkg::DATA_W-1:0]          o_rdata,
  // Arbitration machine, same clock
  input  wire logic [anpm_pkg::CODE_W-1:0]          i_arb_code,
  input  wire logic                                 i_restart,
  // Line status from the receive clock side
  input  wire anpm_pkg::anpm_line_t                 i_line,
  // Interrupt
  output logic                                      o_irq
);

  import anpm_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic code_legal(input logic [CODE_W-1:0] c);
    code_legal = (c <= CODE_LAST_ARB) || (c == CODE_COMPLETE);
  endfunction : code_legal

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] off);
    addr_hit = (a == off);
  endfunction : addr_hit

  // ----------------------------------------------------------------
  // Line status synchroniser
  // ----------------------------------------------------------------
  anpm_line_t line_s;
  logic [LINE_W-1:0] line_raw;

  anpm_sync #(
    .W       (LINE_W)
  ) u_line_sync (
    .i_mclk  (i_mclk),
    .i_nrst  (i_nrst),
    .i_async (i_line),
    .o_sync  (line_raw)
  );

  assign line_s = anpm_line_t'(line_raw);

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  logic sum_rd;
  logic bas_rd;
  logic sts_rd;
  logic msk_rd;
  logic sts_wr;
  logic msk_wr;

  assign sum_rd = i_req.rd && addr_hit(i_req.addr, OFF_SUMMARY);
  assign bas_rd = i_req.rd && addr_hit(i_req.addr, OFF_BASIC);
  assign sts_rd = i_req.rd && addr_hit(i_req.addr, OFF_IRQ_STS);
  assign msk_rd = i_req.rd && addr_hit(i_req.addr, OFF_IRQ_MASK);
  assign sts_wr = i_req.wr && addr_hit(i_req.addr, OFF_IRQ_STS);
  assign msk_wr = i_req.wr && addr_hit(i_req.addr, OFF_IRQ_MASK);

  // ----------------------------------------------------------------
  // Monitor state
  // ----------------------------------------------------------------
  anpm_state_t st_q;
  anpm_state_t st_d;
  logic        arb_done;

  assign arb_done = (i_arb_code == CODE_COMPLETE);

  always_comb begin
    st_d = st_q;
    case (st_q)
      ANPM_IDLE:  st_d = ANPM_TRACK;
      ANPM_TRACK: if (arb_done) begin
        st_d = ANPM_DONE;
      end
      ANPM_DONE:  st_d = ANPM_DONE;
      default:    st_d = ANPM_IDLE;
    endcase
    if (i_restart) begin
      st_d = ANPM_IDLE;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= ANPM_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Held progress code
  // ----------------------------------------------------------------
  // A read during completion loads "complete, lower bits clear", so the
  // next read reports a settled link rather than the completion event.
  logic [CODE_W-1:0] held_q;
  logic [CODE_W-1:0] held_d;
  logic [CODE_W-1:0] rd_load;

  assign rd_load = arb_done ? CODE_DONE_RD : i_arb_code;

  always_comb begin
    held_d = held_q;
    if (sum_rd) begin
      if (code_legal(i_arb_code)) begin
        held_d = rd_load;
      end
    end else if (st_q != ANPM_DONE) begin
      if (code_legal(i_arb_code) && (i_arb_code > held_q)) begin
        held_d = i_arb_code;
      end
    end
  end

  // Restart does not touch this register; reset returns it to CODE_IDLE
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      held_q <= CODE_IDLE;
    end else begin
      held_q <= held_d;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] irq_sts_q;
  logic [IRQ_W-1:0] irq_msk_q;
  logic [IRQ_W-1:0] irq_evt;
  logic             link_d1_q;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      link_d1_q <= 1'b0;
    end else begin
      link_d1_q <= line_s.link;
    end
  end

  always_comb begin
    irq_evt                  = '0;
    irq_evt[IRQ_CMPL_BIT]    = (st_q == ANPM_TRACK) && arb_done;
    irq_evt[IRQ_LINKDN_BIT]  = link_d1_q && !line_s.link;
    irq_evt[IRQ_RESTART_BIT] = i_restart;
  end

  // A new event in the clearing cycle stays set
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_sts_q <= '0;
    end else if (sts_wr) begin
      irq_sts_q <= (irq_sts_q & ~i_req.wdata[IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_sts_q <= irq_sts_q | irq_evt;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_msk_q <= IRQ_MASK_RST;
    end else if (msk_wr) begin
      irq_msk_q <= i_req.wdata[IRQ_W-1:0];
    end
  end

  assign o_irq = |(irq_sts_q & irq_msk_q);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // The summary word samples the held code in the same edge that the
  // read reloads it, so no arbitration step is lost or counted twice.
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  always_comb begin
    rdata_d = RDATA_RST;
    if (sum_rd) begin
      rdata_d[SUM_RATE_BIT]               = line_s.rate;
      rdata_d[SUM_DUPLEX_BIT]             = line_s.duplex;
      rdata_d[SUM_PROG_HI:SUM_PROG_LO]    = held_q[CODE_W-2:0];
      rdata_d[SUM_CMPL_BIT]               = held_q[CODE_W-1];
      rdata_d[SUM_LINK_BIT]               = line_s.link;
    end else if (bas_rd) begin
      rdata_d[BAS_CMPL_BIT]               = held_q[CODE_W-1];
      rdata_d[BAS_LINK_BIT]               = line_s.link;
    end else if (sts_rd) begin
      rdata_d[IRQ_W-1:0]                  = irq_sts_q;
    end else if (msk_rd) begin
      rdata_d[IRQ_W-1:0]                  = irq_msk_q;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_q <= RDATA_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);

  AST_RATE_DUPLEX: assert property (
    sum_rd |=> (o_rdata[SUM_RATE_BIT] == $past(line_s.rate)) &&
               (o_rdata[SUM_DUPLEX_BIT] == $past(line_s.duplex)))
    else $error("summary rate or duplex bit wrong");

  AST_LINK_CMPL: assert property (
    sum_rd |=> (o_rdata[SUM_LINK_BIT] == $past(line_s.link)) &&
               (o_rdata[SUM_CMPL_BIT] == $past(held_q[3])))
    else $error("summary link or complete bit wrong");

  AST_PRIOR_VALUE: assert property (
    sum_rd |=> (o_rdata[SUM_PROG_HI:SUM_PROG_LO] == $past(held_q[2:0])))
    else $error("summary read did not return the prior code");

  AST_LEGAL_CODE: assert property (
    (held_q <= CODE_LAST_ARB) || (held_q == CODE_COMPLETE))
    else $error("held code outside the legal set");

  AST_ONLY_RISES: assert property (
    !sum_rd |=> (held_q >= $past(held_q)))
    else $error("held code fell without a read");

  AST_READ_LOAD: assert property (
    (sum_rd && (i_arb_code <= CODE_LAST_ARB)) |=> (held_q == $past(i_arb_code)))
    else $error("read did not load the current code");

  AST_FIRST_DONE_READ: assert property (
    (sum_rd && (held_q == CODE_COMPLETE)) |=>
      (o_rdata[SUM_PROG_HI:SUM_PROG_LO] == 3'h7) && o_rdata[SUM_CMPL_BIT])
    else $error("first read after completion not 1,111");

  AST_LATER_DONE_READ: assert property (
    (sum_rd && arb_done) ##1 (sum_rd && arb_done && !i_restart) |=>
      (o_rdata[SUM_PROG_HI:SUM_PROG_LO] == 3'h0) && o_rdata[SUM_CMPL_BIT])
    else $error("repeat read after completion not 1,000");

  AST_DONE_LOCK: assert property (
    ((st_q == ANPM_DONE) && !sum_rd) |=> $stable(held_q))
    else $error("held code changed after completion without a read");

  AST_RESTART_KEEPS: assert property (
    (i_restart && !sum_rd && (st_q == ANPM_DONE)) |=>
      (st_q == ANPM_IDLE) && $stable(held_q))
    else $error("restart disturbed the held code or state");

  AST_MIRROR: assert property (
    bas_rd |=> (o_rdata[BAS_CMPL_BIT] == $past(held_q[3])))
    else $error("basic status complete bit does not mirror");

  AST_RESET_CLEARS: assert property (
    $rose(i_nrst) |-> (held_q == CODE_IDLE) && (st_q == ANPM_IDLE) &&
                      (o_rdata == RDATA_RST) && !o_irq)
    else $error("reset left progress, state or outputs set");

  AST_STATE_ONEHOT: assert property (
    $onehot(st_q))
    else $error("monitor state not one-hot");

  AST_IDLE_LEAVES: assert property (
    ((st_q == ANPM_IDLE) && !i_restart) |=> (st_q == ANPM_TRACK))
    else $error("monitor did not leave idle");

  AST_RESTART_IDLE: assert property (
    i_restart |=> (st_q == ANPM_IDLE))
    else $error("restart did not idle the monitor");

  AST_TRACK_DONE: assert property (
    ((st_q == ANPM_TRACK) && arb_done && !i_restart) |=> (st_q == ANPM_DONE))
    else $error("completion code did not lock the monitor");

  AST_DONE_HOLDS: assert property (
    ((st_q == ANPM_DONE) && !i_restart) |=> (st_q == ANPM_DONE))
    else $error("monitor left completion without a restart");

  AST_RISE_LOAD: assert property (
    (!sum_rd && (st_q != ANPM_DONE) && code_legal(i_arb_code) && (i_arb_code > held_q))
      |=> (held_q == $past(i_arb_code)))
    else $error("greater code not taken into the held code");

  AST_DONE_RD_LOAD: assert property (
    (sum_rd && arb_done) |=> (held_q == CODE_DONE_RD))
    else $error("read at completion did not load complete with lower bits clear");

  AST_BASIC_NO_LOAD: assert property (
    (bas_rd && (st_q == ANPM_DONE)) |=> $stable(held_q))
    else $error("basic status read changed the held code");

  AST_BASIC_LINK: assert property (
    bas_rd |=> (o_rdata[BAS_LINK_BIT] == $past(line_s.link)))
    else $error("basic status link bit wrong");

  AST_NO_READ_ZERO: assert property (
    !i_req.rd |=> (o_rdata == RDATA_RST))
    else $error("read data not clear outside a read");

  // Every event sets its sticky bit, even in a clearing cycle
  AST_CMPL_SETS: assert property (
    ((st_q == ANPM_TRACK) && arb_done) |=> irq_sts_q[IRQ_CMPL_BIT])
    else $error("completion event did not set its status bit");

  AST_LINKDN_SETS: assert property (
    (link_d1_q && !line_s.link) |=> irq_sts_q[IRQ_LINKDN_BIT])
    else $error("link fall did not set its status bit");

  AST_RESTART_SETS: assert property (
    i_restart |=> irq_sts_q[IRQ_RESTART_BIT])
    else $error("restart did not set its status bit");

  AST_W1C_CLEARS: assert property (
    (sts_wr && i_req.wdata[IRQ_CMPL_BIT] && !irq_evt[IRQ_CMPL_BIT]) |=>
      !irq_sts_q[IRQ_CMPL_BIT])
    else $error("writing one did not clear the completion status bit");

  AST_MASK_WRITE: assert property (
    msk_wr |=> (irq_msk_q == $past(i_req.wdata[IRQ_W-1:0])))
    else $error("mask write did not land");

endmodule : anpm_monitor

// [core/anpm_sync.sv]
`timescale 1ns/100ps

module anpm_sync #(
  parameter int unsigned W = 3
) (
  // Clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_nrst,
  // Levels from outside this clock domain
  input  wire logic [W-1:0] i_async,
  // Synchronised levels
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // The first stage feeds only the second stage
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule : anpm_sync

// [pkg/anpm_pkg.sv]
package anpm_pkg;

  // ----------------------------------------------------------------
  // Register port geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CODE_W = 4;
  localparam int unsigned LINE_W = 3;
  localparam int unsigned IRQ_W  = 3;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_SUMMARY  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_BASIC    = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STS  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h0c;

  // ----------------------------------------------------------------
  // Summary status register fields
  // ----------------------------------------------------------------
  localparam int unsigned SUM_RATE_BIT   = 15;
  localparam int unsigned SUM_DUPLEX_BIT = 14;
  localparam int unsigned SUM_PROG_HI    = 13;
  localparam int unsigned SUM_PROG_LO    = 11;
  localparam int unsigned SUM_CMPL_BIT   = 4;
  localparam int unsigned SUM_LINK_BIT   = 0;

  // Basic status register fields
  localparam int unsigned BAS_CMPL_BIT = 5;
  localparam int unsigned BAS_LINK_BIT = 2;

  // Interrupt status and mask fields
  localparam int unsigned IRQ_CMPL_BIT    = 0;
  localparam int unsigned IRQ_LINKDN_BIT  = 1;
  localparam int unsigned IRQ_RESTART_BIT = 2;

  // ----------------------------------------------------------------
  // Progress codes and reset values
  // ----------------------------------------------------------------
  localparam logic [CODE_W-1:0] CODE_IDLE     = 4'h0;
  localparam logic [CODE_W-1:0] CODE_LAST_ARB = 4'h8;
  localparam logic [CODE_W-1:0] CODE_COMPLETE = 4'hf;
  localparam logic [CODE_W-1:0] CODE_DONE_RD  = 4'h8;
  localparam logic [IRQ_W-1:0]  IRQ_MASK_RST  = 3'h0;
  localparam logic [DATA_W-1:0] RDATA_RST     = 16'h0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ANPM_IDLE  = 3'b001,
    ANPM_TRACK = 3'b010,
    ANPM_DONE  = 3'b100
  } anpm_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } anpm_req_t;

  typedef struct packed {
    logic rate;
    logic duplex;
    logic link;
  } anpm_line_t;

endpackage : anpm_pkg

// [testbench/anpm_mgr.sv]
`timescale 1ns/100ps

module anpm_mgr (
  // Clock
  input  wire logic           i_mclk,
  // Register port towards the device
  output anpm_pkg::anpm_req_t o_req
);
  import anpm_pkg::*;

  initial o_req = '0;

  // Idle cycles invert address and data so nothing leans on stale values
  task automatic idle();
    @(posedge i_mclk);
    o_req <= '{addr: ~o_req.addr, wdata: ~o_req.wdata, wr: 1'b0, rd: 1'b0};
  endtask : idle

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_mclk);
    o_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge i_mclk);
    o_req <= '{addr: a, wdata: ~o_req.wdata, wr: 1'b0, rd: 1'b1};
  endtask : rd

  // History first, then the present state, back to back
  task automatic read_twice();
    rd(OFF_SUMMARY);
    rd(OFF_SUMMARY);
    idle();
  endtask : read_twice
endmodule : anpm_mgr

// [testbench/tb.sv]
`timescale 1ns/100ps

module tb;
  import anpm_pkg::*;

  logic              i_mclk;
  logic              i_nrst;
  logic              i_restart;
  logic              o_irq;
  anpm_req_t         req;
  anpm_line_t        i_line;
  anpm_line_t        ls1;
  anpm_line_t        ls2;
  anpm_line_t        lprev;
  logic [CODE_W-1:0] i_arb_code;
  logic [CODE_W-1:0] held;
  logic [DATA_W-1:0] o_rdata;
  logic [DATA_W-1:0] exp_rd;
  logic [2:0]        sts;
  logic [2:0]        mask;
  logic [31:0]       seed;
  logic [31:0]       r;
  logic [7:0]        addrs [5];
  int                st;
  int                n_fail;
  int                compares;

  anpm_mgr u_anpm_mgr (.i_mclk(i_mclk), .o_req(req));

  anpm_monitor u_anpm_monitor (
    .i_mclk    (i_mclk),
    .i_nrst    (i_nrst),
    .i_req     (req),
    .o_rdata   (o_rdata),
    .i_arb_code(i_arb_code),
    .i_restart (i_restart),
    .i_line    (i_line),
    .o_irq     (o_irq)
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict

  task automatic drv(input logic [3:0] c, input int n);
    i_arb_code <= c;
    repeat (n) u_anpm_mgr.idle();
  endtask : drv

  // ----------------------------------------------------------------
  // Reference model, one step per edge
  // ----------------------------------------------------------------
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      held = '0;
      st = 0;
      sts = '0;
      mask = '0;
      exp_rd = '0;
      {ls1, ls2, lprev} = '0;
    end else begin
      exp_rd = '0;
      if (req.rd) begin
        case (req.addr)
          OFF_SUMMARY: exp_rd = {ls2.rate, ls2.duplex, held[2:0], 6'h0, held[3], 3'h0, ls2.link};
          OFF_BASIC:   exp_rd = {10'h0, held[3], 2'h0, ls2.link, 2'h0};
          OFF_IRQ_STS:  exp_rd = {13'h0, sts};
          OFF_IRQ_MASK: exp_rd = {13'h0, mask};
          default:     exp_rd = '0;
        endcase
      end
      if (req.rd && req.addr == OFF_SUMMARY) begin
        if (i_arb_code <= 4'h8) held = i_arb_code;
        else if (i_arb_code == 4'hf) held = CODE_DONE_RD;
      end else if (st != 2 && i_arb_code > held && (i_arb_code <= 4'h8 || i_arb_code == 4'hf)) begin
        held = i_arb_code;
      end
      if (req.wr && req.addr == OFF_IRQ_STS) sts = sts & ~req.wdata[2:0];
      if (req.wr && req.addr == OFF_IRQ_MASK) mask = req.wdata[2:0];
      sts = sts | {i_restart, lprev.link & ~ls2.link, st == 1 && i_arb_code == 4'hf};
      if (i_restart) st = 0;
      else if (st == 0) st = 1;
      else if (st == 1 && i_arb_code == 4'hf) st = 2;
      lprev = ls2;
      ls2 = ls1;
      ls1 = i_line;
    end
  end

  always @(negedge i_mclk) begin
    if (i_nrst) begin
      chk("rdata", exp_rd, o_rdata);
      chk("irq", {15'h0, |(sts & mask)}, {15'h0, o_irq});
    end
  end

  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  initial begin
    #(20000 * 5);
    n_fail++;
    print_verdict();
  end

  initial begin
    {i_nrst, i_restart, i_arb_code, i_line} = '0;
    seed = 32'h3b2ede3e;
    addrs = '{OFF_SUMMARY, OFF_BASIC, OFF_IRQ_STS, OFF_IRQ_MASK, 8'h10};
    repeat (2) @(posedge i_mclk);
    i_nrst <= 1'b1;
    u_anpm_mgr.rd(OFF_SUMMARY);
    u_anpm_mgr.wr(OFF_IRQ_MASK, 16'h0007);
    drv(4'h3, 2);
    drv(4'h1, 2);
    drv(4'h5, 2);
    u_anpm_mgr.read_twice();
    i_line <= 3'b111;
    drv(4'hf, 5);
    u_anpm_mgr.read_twice();
    drv(4'h2, 3);
    u_anpm_mgr.rd(OFF_SUMMARY);
    u_anpm_mgr.rd(OFF_BASIC);
    u_anpm_mgr.rd(OFF_IRQ_STS);
    u_anpm_mgr.wr(OFF_IRQ_STS, 16'h0001);
    i_restart <= 1'b1;
    u_anpm_mgr.idle();
    i_restart <= 1'b0;
    u_anpm_mgr.rd(OFF_BASIC);
    i_line <= 3'b000;
    drv(4'h0, 5);
    u_anpm_mgr.rd(OFF_IRQ_STS);
    repeat (3000) begin
      r = rnd();
      i_arb_code <= (r[11:8] % 10 == 9) ? 4'hf : 4'(r[11:8] % 10);
      i_restart <= (r[31:27] == 5'h0);
      if (r[26:21] == 6'h0) i_line <= r[14:12];
      case (r[2:0])
        3'h0, 3'h1: u_anpm_mgr.rd(addrs[r[5:3] % 5]);
        3'h2, 3'h3: u_anpm_mgr.wr(addrs[r[5:3] % 5], r[31:16]);
        default: u_anpm_mgr.idle();
      endcase
    end
    i_nrst <= 1'b0;
    u_anpm_mgr.idle();
    i_nrst <= 1'b1;
    u_anpm_mgr.read_twice();
    u_anpm_mgr.idle();
    print_verdict();
  end
endmodule : tb
